// ---- dpmb_pkg.sv ----
// dpmb_pkg: constants, types and states of the dual-port mailbox host.
// assumes a 125 MHz core clock and one port of a 64K-deep, 18-bit RAM.
package dpmb_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 18;
   localparam int CNT_W  = 4;
   localparam int CLK_PS = 8000;

   // mailbox words at the top of the array
   localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 16'hFFFF;
   localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR  = 16'hFFFE;
   localparam logic [2:0]        TOK_IDX_W_MSB   = 3'h2;

   // device timing in ns (slowest speed grade)
   localparam int T_ACCESS_NS = 25;
   localparam int T_PWE_NS    = 22;
   localparam int T_SETTLE_NS = 20;
   localparam int T_RECOV_NS  = 10;
   localparam int T_RETRY_NS  = 25;

   // least times, rounded up to whole cycles
   localparam int ACCESS_CYC = (T_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int PWE_CYC    = (T_PWE_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int SETTLE_CYC = (T_SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int RECOV_CYC  = (T_RECOV_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int RETRY_CYC  = (T_RETRY_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int SYNC_CYC   = 2;

   // last value of the phase counter in each phase
   localparam logic [CNT_W-1:0] SETTLE_LAST =
      CNT_W'(SETTLE_CYC + SYNC_CYC - 1);
   localparam logic [CNT_W-1:0] READ_LAST  = CNT_W'(ACCESS_CYC + SYNC_CYC - 1);
   localparam logic [CNT_W-1:0] PWE_LAST   = CNT_W'(PWE_CYC - 1);
   localparam logic [CNT_W-1:0] RECOV_LAST = CNT_W'(RECOV_CYC - 1);
   localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_CYC - 1);

   typedef enum logic [2:0] {
      OP_MEM_RD   = 3'h0,
      OP_MEM_WR   = 3'h1,
      OP_MBX_SEND = 3'h2,
      OP_MBX_READ = 3'h3,
      OP_TOK_ACQ  = 3'h4,
      OP_TOK_REL  = 3'h5,
      OP_TOK_RD   = 3'h6
   } dpmb_op_t;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,
      ST_SETUP  = 5'h02,
      ST_STROBE = 5'h04,
      ST_HOLD   = 5'h08,
      ST_RECOV  = 5'h10
   } dpmb_st_t;

   typedef struct packed {
      dpmb_op_t          op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dpmb_cmd_t;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic              owned;
      logic              busy_seen;
   } dpmb_rsp_t;

   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              rw_n;
      logic              sel_n;
      logic              be_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic              doe;
   } dpmb_pins_t;

   localparam dpmb_pins_t PINS_RST = '{ce_n: 1'b1, oe_n: 1'b1, rw_n: 1'b1,
      sel_n: 1'b1, be_n: 1'b1, addr: 16'h0000, dout: 18'h00000, doe: 1'b0};

   typedef struct packed {
      dpmb_st_t         st;
      dpmb_pins_t       pins;
      dpmb_rsp_t        rsp;
      logic [CNT_W-1:0] cnt;
      logic             tok;
      logic             wr;
      logic             acq;
      logic             fin;
      logic             done;
      logic             ready;
      logic             int_o;
   } dpmb_state_t;

endpackage

// ---- dpmb_sync.sv ----
// dpmb_sync: two-flop synchroniser for a bus of pin levels.
// assumes each bit is a level that holds for several core cycles.
`timescale 1ns/1ps
`default_nettype none
module dpmb_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [1:0][W-1:0] stg_r;
   logic [1:0][W-1:0] stg_nxt;

   always_comb begin
      stg_nxt[0] = d_i;
      stg_nxt[1] = stg_r[0];
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stg_r <= {RST_VAL, RST_VAL};
      end else begin
         stg_r <= stg_nxt;
      end
   end

   assign q_o = stg_r[1];
endmodule
`default_nettype wire

// ---- dpmb_host.sv ----
// dpmb_host: controller driving one port of an asynchronous dual-port
// RAM: array words, mailboxes, busy retry and token latches.
// assumes the device pins are asynchronous; all device inputs are synchronised.
// Function
// - array reads drive chip select and output enable both active.
// - token reads use token select instead of chip select, with output enable.
// - without message passing, keep interrupt flag away from interrupt input.
// - delay writes until busy has settled after select or address match.
// - acquire by writing zero then reading back; one means keep polling.
// - after a token write, deselect for the recovery interval before reading.
// - chip select inactive for token access; address bits 0-2 pick latch.
`timescale 1ns/1ps
`default_nettype none
module dpmb_host (
   // clock and reset
   input  wire logic                      CORE_CLK_I,
   input  wire logic                      RST_N_I,
   // user command side
   input  wire logic                      CMD_VALID_I,
   input  wire dpmb_pkg::dpmb_cmd_t       CMD_I,
   input  wire logic                      PORT_RIGHT_I,
   input  wire logic                      MSG_EN_I,
   output logic                           CMD_READY_O,
   output logic                           DONE_O,
   output dpmb_pkg::dpmb_rsp_t            RSP_O,
   output logic                           INT_O,
   // device port pins
   output logic                           CE_N_O,
   output logic                           OE_N_O,
   output logic                           RW_N_O,
   output logic                           TOKEN_LATCH_SELECT_N_O,
   output logic                           BE_N_O,
   output logic [dpmb_pkg::ADDR_W-1:0]    ADDR_O,
   output logic [dpmb_pkg::DATA_W-1:0]    DQ_O,
   output logic                           DQ_OE_O,
   input  wire logic [dpmb_pkg::DATA_W-1:0] DQ_I,
   input  wire logic                      BUSY_N_I,
   input  wire logic                      INT_N_I
);
   import dpmb_pkg::*;

   dpmb_state_t       s_r;
   dpmb_state_t       s_nxt;
   logic [DATA_W-1:0] dq_s;
   logic              busy_n_s;
   logic              int_n_s;

   dpmb_sync #(
      .W       (DATA_W + 2),
      .RST_VAL ({2'b11, {DATA_W{1'b0}}})
   ) u_sync (
      .clk_i   (CORE_CLK_I),
      .rst_n_i (RST_N_I),
      .d_i     ({BUSY_N_I, INT_N_I, DQ_I}),
      .q_o     ({busy_n_s, int_n_s, dq_s})
   );

   // select the device for the access held in the state
   function automatic dpmb_pins_t sel_on(dpmb_pins_t p, logic tok, logic wr);
      dpmb_pins_t q;
      q       = p;
      q.ce_n  = tok;
      q.sel_n = ~tok;
      q.be_n  = tok;
      q.oe_n  = wr;
      q.rw_n  = 1'b1;
      q.doe   = wr;
      return q;
   endfunction

   function automatic dpmb_pins_t sel_off(dpmb_pins_t p);
      dpmb_pins_t q;
      q       = p;
      q.ce_n  = 1'b1;
      q.sel_n = 1'b1;
      q.be_n  = 1'b1;
      q.oe_n  = 1'b1;
      q.rw_n  = 1'b1;
      q.doe   = 1'b0;
      return q;
   endfunction

   always_comb begin
      s_nxt       = s_r;
      s_nxt.done  = 1'b0;
      s_nxt.int_o = MSG_EN_I & ~int_n_s;
      case (s_r.st)
         ST_IDLE: begin
            s_nxt.ready = 1'b1;
            if (CMD_VALID_I) begin
               s_nxt.ready = 1'b0;
               s_nxt.rsp   = '0;
               s_nxt.cnt   = '0;
               s_nxt.fin   = 1'b0;
               s_nxt.tok   = CMD_I.op inside {OP_TOK_ACQ, OP_TOK_REL,
                                              OP_TOK_RD};
               s_nxt.wr    = CMD_I.op inside {OP_MEM_WR, OP_MBX_SEND,
                                              OP_TOK_ACQ, OP_TOK_REL};
               s_nxt.acq   = CMD_I.op == OP_TOK_ACQ;
               s_nxt.pins.dout = CMD_I.wdata;
               s_nxt.pins.addr = CMD_I.addr;
               case (CMD_I.op)
                  OP_MBX_SEND: s_nxt.pins.addr = PORT_RIGHT_I ?
                     MBOX_LEFT_ADDR : MBOX_RIGHT_ADDR;
                  OP_MBX_READ: s_nxt.pins.addr = PORT_RIGHT_I ?
                     MBOX_RIGHT_ADDR : MBOX_LEFT_ADDR;
                  OP_TOK_ACQ, OP_TOK_REL, OP_TOK_RD: begin
                     s_nxt.pins.addr = {13'h0000, CMD_I.addr[2:0]};
                     s_nxt.pins.dout = {{(DATA_W-1){1'b0}},
                                        CMD_I.op == OP_TOK_REL};
                  end
                  default: ;
               endcase
               s_nxt.pins = sel_on(s_nxt.pins, s_nxt.tok, s_nxt.wr);
               s_nxt.st   = ST_SETUP;
            end
         end
         ST_SETUP: begin
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_r.wr && s_r.cnt == SETTLE_LAST) begin
               s_nxt.cnt = '0;
               if (!s_r.tok && !busy_n_s) begin
                  // lost arbitration: back off and retry the write
                  s_nxt.rsp.busy_seen = 1'b1;
                  s_nxt.pins = sel_off(s_r.pins);
                  s_nxt.st   = ST_RECOV;
               end else begin
                  s_nxt.pins.rw_n = 1'b0;
                  s_nxt.st        = ST_STROBE;
               end
            end else if (!s_r.wr && s_r.cnt == READ_LAST) begin
               s_nxt.cnt       = '0;
               s_nxt.rsp.rdata = dq_s;
               s_nxt.rsp.owned = s_r.tok & ~dq_s[0];
               s_nxt.pins      = sel_off(s_r.pins);
               s_nxt.st        = ST_RECOV;
               if (!s_r.tok && !busy_n_s) begin
                  s_nxt.rsp.busy_seen = 1'b1;
               end else if (!(s_r.acq && dq_s[0])) begin
                  // finished; a held latch keeps the acquire polling
                  s_nxt.done  = 1'b1;
                  s_nxt.ready = 1'b1;
                  s_nxt.st    = ST_IDLE;
               end
            end
         end
         ST_STROBE: begin
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_r.cnt == PWE_LAST) begin
               s_nxt.cnt       = '0;
               s_nxt.pins.rw_n = 1'b1;
               s_nxt.st        = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // data stays one cycle past the write end, then release
            s_nxt.pins = sel_off(s_r.pins);
            s_nxt.fin  = ~s_r.acq;
            s_nxt.wr   = 1'b0;
            s_nxt.st   = ST_RECOV;
         end
         ST_RECOV: begin
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_r.cnt == (s_r.tok ? RECOV_LAST : RETRY_LAST)) begin
               s_nxt.cnt = '0;
               if (s_r.fin) begin
                  s_nxt.done  = 1'b1;
                  s_nxt.ready = 1'b1;
                  s_nxt.st    = ST_IDLE;
               end else begin
                  s_nxt.pins = sel_on(s_r.pins, s_r.tok, s_r.wr);
                  s_nxt.st   = ST_SETUP;
               end
            end
         end
         default: begin
            s_nxt.pins = PINS_RST;
            s_nxt.st   = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         s_r <= '{st: ST_IDLE, pins: PINS_RST, rsp: '0, cnt: '0,
                  tok: 1'b0, wr: 1'b0, acq: 1'b0, fin: 1'b0,
                  done: 1'b0, ready: 1'b0, int_o: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign CMD_READY_O            = s_r.ready;
   assign DONE_O                 = s_r.done;
   assign RSP_O                  = s_r.rsp;
   assign INT_O                  = s_r.int_o;
   assign CE_N_O                 = s_r.pins.ce_n;
   assign OE_N_O                 = s_r.pins.oe_n;
   assign RW_N_O                 = s_r.pins.rw_n;
   assign TOKEN_LATCH_SELECT_N_O = s_r.pins.sel_n;
   assign BE_N_O                 = s_r.pins.be_n;
   assign ADDR_O                 = s_r.pins.addr;
   assign DQ_O                   = s_r.pins.dout;
   assign DQ_OE_O                = s_r.pins.doe;

   // checking helpers: select-low and token-deselect run lengths
   logic [7:0] ce_lo_cnt_r;
   logic [7:0] sel_hi_cnt_r;
   logic       tok_wr_last_r;

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         ce_lo_cnt_r   <= 8'h00;
         sel_hi_cnt_r  <= 8'hFF;
         tok_wr_last_r <= 1'b0;
      end else begin
         ce_lo_cnt_r  <= s_r.pins.ce_n ? 8'h00 : ce_lo_cnt_r + 8'h01;
         sel_hi_cnt_r <= !s_r.pins.sel_n ? 8'h00 :
                         (sel_hi_cnt_r == 8'hFF ? 8'hFF : sel_hi_cnt_r + 8'h01);
         if (!s_r.pins.sel_n && !s_r.pins.rw_n) begin
            tok_wr_last_r <= 1'b1;
         end else if (!s_r.pins.sel_n && !s_r.pins.oe_n) begin
            tok_wr_last_r <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);

   read_ce_oe_a: assert property (
      s_r.st == ST_SETUP && !s_r.wr && !s_r.tok && s_r.cnt == READ_LAST
      |-> !CE_N_O && !OE_N_O && TOKEN_LATCH_SELECT_N_O && $stable(CE_N_O))
      else $error("array read sampled without chip select and output enable");
   tok_read_sel_a: assert property (
      s_r.st == ST_SETUP && !s_r.wr && s_r.tok && s_r.cnt == READ_LAST
      |-> !TOKEN_LATCH_SELECT_N_O && !OE_N_O && CE_N_O)
      else $error("token read sampled without token select");
   tok_ce_high_a: assert property (
      !TOKEN_LATCH_SELECT_N_O |-> CE_N_O)
      else $error("chip select active during token access");
   tok_addr_low_a: assert property (
      !TOKEN_LATCH_SELECT_N_O |-> ADDR_O[ADDR_W-1:3] == 13'h0000)
      else $error("token access with upper address bits set");
   wr_settle_a: assert property (
      $fell(RW_N_O) && !CE_N_O
      |-> ce_lo_cnt_r == 8'(SETTLE_LAST) + 8'h01)
      else $error("array write strobe before busy settled");
   wr_busy_abort_a: assert property (
      s_r.st == ST_SETUP && s_r.wr && !s_r.tok && s_r.cnt == SETTLE_LAST
      && !busy_n_s |=> RW_N_O && CE_N_O && !DQ_OE_O)
      else $error("write strobed although busy was active");
   tok_recov_a: assert property (
      $fell(TOKEN_LATCH_SELECT_N_O) && !OE_N_O && tok_wr_last_r
      |-> sel_hi_cnt_r >= 8'(RECOV_CYC))
      else $error("token read too soon after token write");
   acq_wr_zero_a: assert property (
      !TOKEN_LATCH_SELECT_N_O && !RW_N_O && s_r.acq
      |-> DQ_OE_O && DQ_O[0] == 1'b0)
      else $error("token acquire did not write zero");
   acq_owned_a: assert property (
      DONE_O && s_r.acq |-> RSP_O.owned && RSP_O.rdata[0] == 1'b0)
      else $error("acquire finished without owning the latch");
   int_gate_a: assert property (
      !MSG_EN_I |=> !INT_O)
      else $error("interrupt forwarded with message passing off");
endmodule
`default_nettype wire

// ---- dpmb_dev_model.sv ----
// dpmb_dev_model: one port of the dual-port RAM as the host sees it,
// with mailbox flags and token latches; the far port is driven by tasks.
// assumes busy comes from the bench, as from a master device.
`timescale 1ns/1ps
`default_nettype none
module dpmb_dev_model
   import dpmb_pkg::*;
(
   // host port pins
   input  wire logic              clk_i,
   input  wire logic              right_i,
   input  wire logic              ce_n_i,
   input  wire logic              oe_n_i,
   input  wire logic              rw_n_i,
   input  wire logic              sel_n_i,
   input  wire logic              be_n_i,
   input  wire logic              doe_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] dq_i,
   input  wire logic              busy_n_i,
   // device answers
   output logic      [DATA_W-1:0] dq_o,
   output logic                   int_n_o
);
   logic [DATA_W-1:0] mem [0:65535];
   logic              int_own, int_far, tok_q, tgl;
   logic [7:0]        req_h, req_f, own_h, own_f;
   wire logic [ADDR_W-1:0] own_mb = right_i ? MBOX_RIGHT_ADDR : MBOX_LEFT_ADDR;
   wire logic [ADDR_W-1:0] far_mb = right_i ? MBOX_LEFT_ADDR : MBOX_RIGHT_ADDR;
   wire logic mem_rd = !ce_n_i && !be_n_i && !oe_n_i && rw_n_i;
   wire logic tok_rd = !sel_n_i && !oe_n_i && rw_n_i && ce_n_i;

   initial begin
      {int_own, int_far, tgl} = 3'h0;
      {req_h, req_f, own_h, own_f} = 32'h0;
      tok_q = 1'b1;
   end
   always @(posedge clk_i) tgl <= ~tgl;

   // only the owner may drop a latch; a waiting request takes it over
   task automatic tok_write(input logic host, input logic [2:0] i,
                            input logic v);
      if (host) req_h[i] = ~v;
      else req_f[i] = ~v;
      if (own_h[i] && !req_h[i]) own_h[i] = 1'b0;
      if (own_f[i] && !req_f[i]) own_f[i] = 1'b0;
      if (!own_h[i] && !own_f[i]) begin
         own_h[i] = req_h[i];
         own_f[i] = req_f[i] & ~req_h[i];
      end
   endtask
   task automatic far_tok_write(input logic [2:0] i, input logic v);
      tok_write(1'b0, i, v);
   endtask
   task automatic far_mbx_write(input logic [DATA_W-1:0] d);
      mem[own_mb] = d;
      int_own = 1'b1;
   endtask

   // writes land at the end of the strobe
   always @(posedge rw_n_i) begin
      // an array write lands only with byte selects low and data driven
      if (!ce_n_i && !be_n_i && doe_i && busy_n_i) begin
         mem[addr_i] = dq_i;
         if (addr_i == far_mb) int_far = 1'b1;
      end else if (!sel_n_i && ce_n_i && doe_i) begin
         tok_write(1'b1, addr_i[2:0], dq_i[0]);
      end
   end
   always @(posedge mem_rd) #1 begin
      if (addr_i == own_mb && busy_n_i) int_own = 1'b0;
   end
   always @(posedge tok_rd) #1 tok_q = ~own_h[addr_i[2:0]];
   // an undriven bus shows a toggling pattern, never the last value
   assign dq_o = mem_rd ? mem[addr_i] : tok_rd ? {DATA_W{tok_q}}
               : ({DATA_W{tgl}} ^ 18'h2AAAA);
   assign int_n_o = ~int_own;
endmodule
`default_nettype wire

// ---- dpmb_tb.sv ----
// testbench: drives dpmb_host commands against the device model.
// assumes the host's latencies as handed over; no random stimulus.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dpmb_pkg::*;
   logic clk, rst_n, valid, ready, done, port_right, msg_en, int_o, busy_n;
   logic ce_n, oe_n, rw_n, sel_n, be_n, dq_oe, int_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] dq_h, dq_d;
   dpmb_cmd_t cmd_s;
   dpmb_rsp_t rsp_o, rsp;
   int mismatches, compares, cycles, n;

   dpmb_host u_dpmb_host (.CORE_CLK_I(clk), .RST_N_I(rst_n),
      .CMD_VALID_I(valid), .CMD_I(cmd_s), .PORT_RIGHT_I(port_right),
      .MSG_EN_I(msg_en), .CMD_READY_O(ready), .DONE_O(done), .RSP_O(rsp_o),
      .INT_O(int_o), .CE_N_O(ce_n), .OE_N_O(oe_n), .RW_N_O(rw_n),
      .TOKEN_LATCH_SELECT_N_O(sel_n), .BE_N_O(be_n), .ADDR_O(addr),
      .DQ_O(dq_h), .DQ_OE_O(dq_oe), .DQ_I(dq_d), .BUSY_N_I(busy_n),
      .INT_N_I(int_n));
   dpmb_dev_model u_dpmb_dev_model (.clk_i(clk), .right_i(port_right),
      .ce_n_i(ce_n), .oe_n_i(oe_n), .rw_n_i(rw_n), .sel_n_i(sel_n),
      .be_n_i(be_n), .doe_i(dq_oe),
      .addr_i(addr), .dq_i(dq_h), .busy_n_i(busy_n), .dq_o(dq_d),
      .int_n_o(int_n));

   task automatic finish_test;
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   // one command: present at an edge, count cycles from take to done
   task automatic do_cmd(input dpmb_op_t op, input logic [15:0] a,
                         input logic [17:0] d, output int cnt);
      @(posedge clk);
      valid <= 1'b1;
      cmd_s <= '{op: op, addr: a, wdata: d};
      do @(posedge clk); while (ready !== 1'b1);
      valid <= 1'b0;
      cnt = 0;
      do begin
         @(posedge clk);
         #1;
         cnt++;
      end while (done !== 1'b1);
      rsp = rsp_o;
   endtask

   task automatic t_mem;
      do_cmd(OP_MEM_WR, 16'h1234, 18'h2A5C3, n);
      chk(n, SETTLE_CYC + SYNC_CYC + PWE_CYC + 1 + RETRY_CYC);
      chk(u_dpmb_dev_model.mem[16'h1234], 18'h2A5C3);
      do_cmd(OP_MEM_RD, 16'h1234, 18'h00000, n);
      chk(n, ACCESS_CYC + SYNC_CYC);
      chk(rsp.rdata, 18'h2A5C3);
   endtask
   task automatic t_mbx;
      do_cmd(OP_MBX_SEND, 16'h0000, 18'h1F00F, n);
      chk(u_dpmb_dev_model.mem[16'hFFFF], 18'h1F00F);
      chk(u_dpmb_dev_model.int_far, 1'b1);
      u_dpmb_dev_model.far_mbx_write(18'h0BEEF);
      repeat (5) @(posedge clk);
      chk(int_o, 1'b1);
      // the opposite mailbox is read while our own flag stands
      do_cmd(OP_MEM_RD, 16'hFFFF, 18'h00000, n);
      chk(rsp.rdata, 18'h1F00F);
      repeat (5) @(posedge clk);
      chk(int_o, 1'b1);
      msg_en <= 1'b0;
      repeat (2) @(posedge clk);
      chk(int_o, 1'b0);
      msg_en <= 1'b1;
      do_cmd(OP_MBX_READ, 16'h0000, 18'h00000, n);
      chk(rsp.rdata, 18'h0BEEF);
      repeat (5) @(posedge clk);
      chk(int_o, 1'b0);
      port_right <= 1'b1;
      do_cmd(OP_MBX_SEND, 16'h0000, 18'h00077, n);
      chk(u_dpmb_dev_model.mem[16'hFFFE], 18'h00077);
      @(posedge clk);
      port_right <= 1'b0;
   endtask
   task automatic t_busy;
      int m;
      @(posedge clk);
      busy_n <= 1'b0;
      fork
         do_cmd(OP_MEM_WR, 16'h0042, 18'h3C3C3, m);
         begin
            repeat (30) @(posedge clk);
            busy_n <= 1'b1;
         end
      join
      chk(rsp.busy_seen, 1'b1);
      chk(m > 30, 1'b1);
      chk(u_dpmb_dev_model.mem[16'h0042], 18'h3C3C3);
   endtask
   task automatic t_tok;
      int m;
      do_cmd(OP_TOK_ACQ, 16'hFFF5, 18'h00000, n);
      chk(rsp.owned, 1'b1);
      chk(u_dpmb_dev_model.own_h[5], 1'b1);
      u_dpmb_dev_model.far_tok_write(3'h5, 1'b0);
      do_cmd(OP_TOK_RD, 16'h0005, 18'h00000, n);
      chk(n, ACCESS_CYC + SYNC_CYC);
      chk(rsp.rdata, 18'h00000);
      chk(rsp.owned, 1'b1);
      do_cmd(OP_TOK_REL, 16'h0005, 18'h00000, n);
      chk(n, SETTLE_CYC + SYNC_CYC + PWE_CYC + 1 + RECOV_CYC);
      chk(u_dpmb_dev_model.own_f[5], 1'b1);
      do_cmd(OP_TOK_RD, 16'h0005, 18'h00000, n);
      chk(rsp.rdata, 18'h3FFFF);
      fork
         do_cmd(OP_TOK_ACQ, 16'h0005, 18'h00000, m);
         begin
            repeat (60) @(posedge clk);
            u_dpmb_dev_model.far_tok_write(3'h5, 1'b1);
         end
      join
      chk(rsp.owned, 1'b1);
      chk(m > 60, 1'b1);
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end
   initial begin
      {mismatches, compares, cycles} = '0;
      {rst_n, valid, port_right} = 3'h0;
      {msg_en, busy_n} = 2'h3;
      cmd_s = '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_mem();
      t_mbx();
      t_busy();
      t_tok();
      finish_test();
   end
endmodule
`default_nettype wire
